// ### design/special_register_access.sv
// special-purpose and translation-buffer register set with a wishbone slave port
// Contract
// [RL1] store data kept when store fails
// [RL2] channel control kept when operation fails
// [RL3] bank protect denies user register groups
// [RL4] trap captures decode address into pc0
// [RL5] trap captures execute address into pc1
// [RL6] pc2 holds completed address, informational only
// [RL7] miss loads least recently used hint
// [RL8] count loaded, decremented, seen via control
// [RL9] byte pointer, shift count aliased in status
// [RL10] multiply/divide exceptions gated by environment
// [RL11] trapping instruction opcode is recorded
// [RL12] 128 buffer registers, two per entry
// [RL13] buffer registers only moved, never computed
// [RL14] buffer registers supervisor only, user traps
// [RL15] 8-bit constant replaces one source
// [RL16] 16-bit relative offset, absolute address
// [RL17] single cycle except returns, multiples
// [RL18] floating-point class traps, not executed
// [RL19] assert compares trap on false condition
// [RL20] two sources, one result, any register
// [RL21] funnel shift extracts word from double
// [RL22] protected specials supervisor only, user traps
// [RL23] register zero uses indirect pointer
// [RL24] channel address kept when access fails
// [RL25] trapped access leaves register unchanged
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
module special_register_access (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [11:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic wb_ack_out,
	output logic [31:0] wb_dat_out,
	input wire logic supervisor_in,
	input wire logic chan_start_in,
	input wire logic chan_fail_in,
	input wire logic [31:0] chan_addr_in,
	input wire logic [31:0] chan_data_in,
	input wire logic [15:0] chan_ctrl_in,
	input wire logic mult_start_in,
	input wire logic xfer_in,
	input wire logic tlb_miss_in,
	input wire logic [5:0] lru_in,
	input wire logic int_return_in,
	input wire logic [31:0] pc_decode_in,
	input wire logic [31:0] pc_exec_in,
	input wire logic [31:0] pc_done_in,
	input wire logic [7:0] opcode_in,
	input wire logic op_valid_in,
	input wire logic [7:0] srca_in,
	input wire logic [7:0] srcb_in,
	input wire logic [7:0] dst_in,
	input wire logic use_const_in,
	input wire logic [7:0] const_in,
	input wire logic [31:0] regb_in,
	input wire logic [31:0] dw_hi_in,
	input wire logic [31:0] dw_lo_in,
	input wire logic br_abs_in,
	input wire logic [15:0] br_off_in,
	input wire logic [31:0] pc_in,
	input wire logic fp_op_in,
	input wire logic assert_op_in,
	input wire logic cond_in,
	input wire logic mul_exc_in,
	input wire logic div_exc_in,
	output logic trap_out,
	output logic busy_out,
	output logic restart_vld_out,
	output logic [31:0] restart_pc_out,
	output logic [7:0] eff_a_out,
	output logic [7:0] eff_b_out,
	output logic [7:0] eff_c_out,
	output logic [31:0] opb_out,
	output logic [31:0] extract_out,
	output logic [31:0] target_out
);
	typedef struct packed {
		logic [127:0][31:0] tlb;
		logic [31:0] caddr;
		logic [31:0] cdata;
		logic [15:0] cctrl;
		logic [15:0] bprot;
		logic [31:0] pc0;
		logic [31:0] pc1;
		logic [31:0] pc2;
		logic [5:0] lru;
		logic [1:0] bptr;
		logic [4:0] fsc;
		logic [7:0] cnt;
		logic [1:0] ienv;
		logic [7:0] eop;
		logic [7:0] ipa;
		logic [7:0] ipb;
		logic [7:0] ipc;
		logic cfail;
		logic mult_act;
		logic [1:0] ret_cnt;
		logic restart_vld;
		logic [31:0] restart_pc;
		logic ack;
		logic [31:0] rdata;
		logic trap;
		logic [7:0] effa;
		logic [7:0] effb;
		logic [7:0] effc;
		logic [31:0] opb;
		logic [31:0] ext;
		logic [31:0] tgt;
	} state_t;

	state_t q, d;
	logic hit, deny, wr, viol, trap;
	logic [11:0] idx;
	logic [31:0] rv, m, w;
	logic [7:0] ea, eb, ec;
	logic [63:0] dw;

	// register number zero is replaced by the pointer
	function automatic logic [7:0] eff(input logic [7:0] n, input logic [7:0] p);
		eff = (n == 8'h00) ? p : n;
	endfunction : eff

	// bus decode; idx is the aligned byte address
	assign hit = wb_cyc_in & wb_stb_in;
	assign idx = {wb_adr_in[11:2], 2'h0};
	// only the pointers and status are open to user mode
	assign deny = ~supervisor_in & (idx[9] | ~(idx == spr_pkg::A_IPA | idx == spr_pkg::A_IPB
		| idx == spr_pkg::A_IPC | idx == spr_pkg::A_STAT)); // RL14 RL22
	assign wr = hit & q.ack & wb_we_in & ~deny; // RL25
	assign m = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
	// the write merges lanes into the current read value so narrow fields slice it
	assign w = (rv & ~m) | (wb_dat_in & m);

	// operand numbers after indirection
	assign ea = eff(srca_in, q.ipa); // RL23 RL20
	assign eb = eff(srcb_in, q.ipb); // RL23 RL20
	assign ec = eff(dst_in, q.ipc); // RL23 RL20
	// any touched group whose protect bit is set traps in user mode
	assign viol = ~supervisor_in & (q.bprot[ea[7:4]] | q.bprot[eb[7:4]] | q.bprot[ec[7:4]]); // RL3
	assign dw = {dw_hi_in, dw_lo_in};
	// every trap source folds into one pulse
	assign trap = (hit & q.ack & deny) | (op_valid_in & (viol | fp_op_in // RL18
		| (assert_op_in & ~cond_in) // RL19
		| (mul_exc_in & q.ienv[spr_pkg::IENV_MUL])
		| (div_exc_in & q.ienv[spr_pkg::IENV_DIV]))); // RL10

	// read mux
	always_comb begin
		rv = spr_pkg::RST_WORD;
		case (idx)
			spr_pkg::A_CADDR: rv = q.caddr;
			spr_pkg::A_CDATA: rv = q.cdata;
			spr_pkg::A_CCTRL: rv = {8'h00, q.cnt, q.cctrl}; // RL8
			spr_pkg::A_BPROT: rv = {16'h0000, q.bprot};
			spr_pkg::A_PC0: rv = q.pc0;
			spr_pkg::A_PC1: rv = q.pc1;
			spr_pkg::A_PC2: rv = q.pc2;
			spr_pkg::A_LRU: rv = {26'h0, q.lru};
			spr_pkg::A_ALUST: rv = {25'h0, q.bptr, q.fsc}; // RL9
			spr_pkg::A_BPTR: rv = {30'h0, q.bptr};
			spr_pkg::A_FSC: rv = {27'h0, q.fsc};
			spr_pkg::A_CNT: rv = {24'h0, q.cnt};
			spr_pkg::A_IENV: rv = {30'h0, q.ienv};
			spr_pkg::A_EOP: rv = {24'h0, q.eop};
			spr_pkg::A_IPA: rv = {24'h0, q.ipa};
			spr_pkg::A_IPB: rv = {24'h0, q.ipb};
			spr_pkg::A_IPC: rv = {24'h0, q.ipc};
			spr_pkg::A_STAT: rv = {28'h0, q.cfail, q.mult_act, busy_out, supervisor_in};
			default: rv = spr_pkg::RST_WORD;
		endcase
		if (idx[9]) begin
			rv = q.tlb[idx[8:2]]; // RL12
		end
	end

	// next state: bus first, hardware events after so they win
	always_comb begin
		d = q;
		d.ack = hit & ~q.ack;
		d.trap = trap;
		if (hit & ~q.ack) begin
			d.rdata = deny ? spr_pkg::RST_WORD : rv; // RL14 RL22
		end
		// plain moves only: no arithmetic path reaches these registers
		if (wr & idx[9]) begin
			d.tlb[idx[8:2]] = w; // RL13 RL12
		end
		if (wr) begin
			case (idx)
				spr_pkg::A_CADDR: d.caddr = w;
				spr_pkg::A_CDATA: d.cdata = w;
				spr_pkg::A_CCTRL: begin
					d.cctrl = w[15:0];
					d.cnt = w[spr_pkg::CNT_LSB +: 8]; // RL8
				end
				spr_pkg::A_BPROT: d.bprot = w[15:0];
				spr_pkg::A_PC0: d.pc0 = w;
				spr_pkg::A_PC1: d.pc1 = w;
				spr_pkg::A_PC2: d.pc2 = w;
				spr_pkg::A_LRU: d.lru = w[5:0];
				spr_pkg::A_ALUST: begin
					d.bptr = w[spr_pkg::BPTR_LSB +: 2]; // RL9
					d.fsc = w[4:0]; // RL9
				end
				spr_pkg::A_BPTR: d.bptr = w[1:0];
				spr_pkg::A_FSC: d.fsc = w[4:0];
				spr_pkg::A_CNT: d.cnt = w[7:0]; // RL8
				spr_pkg::A_IENV: d.ienv = w[1:0];
				spr_pkg::A_EOP: d.eop = w[7:0];
				spr_pkg::A_IPA: d.ipa = w[7:0];
				spr_pkg::A_IPB: d.ipb = w[7:0];
				spr_pkg::A_IPC: d.ipc = w[7:0];
				default: d.cfail = q.cfail;
			endcase
		end
		// channel registers load from the pins only at start; a failure leaves them for restart
		if (chan_start_in) begin
			d.caddr = chan_addr_in; // RL24
			d.cdata = chan_data_in; // RL1
			d.cctrl = chan_ctrl_in; // RL2
			d.cfail = 1'b0;
		end
		if (chan_fail_in) begin
			d.cfail = 1'b1;
		end
		// multiple transfers count down; busy until the count empties
		if (mult_start_in) begin
			d.mult_act = 1'b1;
		end else if (q.mult_act & (q.cnt == 8'h00)) begin
			d.mult_act = 1'b0;
		end
		if (xfer_in & q.mult_act & (q.cnt != 8'h00)) begin
			d.cnt = q.cnt - 8'h01; // RL8
		end
		if (tlb_miss_in) begin
			d.lru = lru_in; // RL7
		end
		// return restarts pc1 then pc0; pc2 never takes part
		d.restart_vld = 1'b0;
		if (int_return_in) begin
			d.ret_cnt = spr_pkg::RET_CYC - 2'h1; // RL17
			d.restart_pc = q.pc1; // RL5
			d.restart_vld = 1'b1;
		end else if (q.ret_cnt != 2'h0) begin
			d.ret_cnt = q.ret_cnt - 2'h1;
			d.restart_pc = q.pc0; // RL4 RL6
			d.restart_vld = 1'b1;
		end
		// operand stage results
		if (op_valid_in) begin
			d.effa = ea;
			d.effb = eb;
			d.effc = ec;
			d.opb = use_const_in ? {24'h0, const_in} : regb_in; // RL15
			d.ext = dw[q.fsc +: 32]; // RL21
			d.tgt = br_abs_in ? {14'h0, br_off_in, 2'h0} // RL16
				: pc_in + {{14{br_off_in[15]}}, br_off_in, 2'h0}; // RL16
		end
		if (trap) begin
			d.pc0 = pc_decode_in; // RL4
			d.pc1 = pc_exec_in; // RL5
			d.pc2 = pc_done_in; // RL6
			d.eop = opcode_in; // RL11
		end
	end

	// state register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			q <= '0;
			q.bprot <= spr_pkg::RST_BPROT;
			q.ienv <= spr_pkg::RST_IENV;
		end else begin
			q <= d;
		end
	end

	assign wb_ack_out = q.ack;
	assign wb_dat_out = q.rdata;
	assign trap_out = q.trap;
	// an operand stage that stalls on this keeps every other op single cycle
	assign busy_out = q.mult_act | (q.ret_cnt != 2'h0); // RL17
	assign restart_vld_out = q.restart_vld;
	assign restart_pc_out = q.restart_pc;
	assign eff_a_out = q.effa;
	assign eff_b_out = q.effb;
	assign eff_c_out = q.effc;
	assign opb_out = q.opb;
	assign extract_out = q.ext;
	assign target_out = q.tgt;

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	property p_data_keep;
		chan_fail_in && !chan_start_in && !wr |=> $stable(q.cdata) && $stable(q.caddr);
	endproperty
	a_data_keep: assert property (p_data_keep) else $error("channel data lost"); // RL1
	property p_ctrl_keep;
		chan_fail_in && !chan_start_in && !wr |=> $stable(q.cctrl);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("channel control lost"); // RL2
	property p_bank;
		op_valid_in && viol |=> trap_out;
	endproperty
	a_bank: assert property (p_bank) else $error("bank violation not trapped"); // RL3
	property p_pc0;
		trap |=> q.pc0 == $past(pc_decode_in) && q.eop == $past(opcode_in);
	endproperty
	a_pc0: assert property (p_pc0) else $error("pc0 or opcode not captured"); // RL4
	property p_pc1;
		trap |=> q.pc1 == $past(pc_exec_in) && q.pc2 == $past(pc_done_in);
	endproperty
	a_pc1: assert property (p_pc1) else $error("pc1 or pc2 not captured"); // RL5
	property p_ret;
		int_return_in |=> restart_vld_out && restart_pc_out == $past(q.pc1) ##1 restart_vld_out;
	endproperty
	a_ret: assert property (p_ret) else $error("return sequence wrong"); // RL17
	property p_lru;
		tlb_miss_in |=> q.lru == $past(lru_in);
	endproperty
	a_lru: assert property (p_lru) else $error("lru hint not loaded"); // RL7
	property p_dec;
		xfer_in && q.mult_act && q.cnt != 8'h00 && !wr |=> q.cnt == $past(q.cnt) - 8'h01;
	endproperty
	a_dec: assert property (p_dec) else $error("count not decremented"); // RL8
	property p_env;
		op_valid_in && mul_exc_in && !q.ienv[0] && !viol && !fp_op_in && !assert_op_in
			&& !div_exc_in && !(hit && q.ack && deny) |=> !trap_out;
	endproperty
	a_env: assert property (p_env) else $error("masked multiply exception trapped"); // RL10
	property p_deny;
		hit && q.ack && wb_we_in && deny && idx == spr_pkg::A_BPROT
			|=> trap_out && $stable(q.bprot);
	endproperty
	a_deny: assert property (p_deny) else $error("user write altered protect"); // RL25
	property p_tlb_user;
		hit && !q.ack && !supervisor_in && idx[9] |=> wb_ack_out && wb_dat_out == 32'h0;
	endproperty
	a_tlb_user: assert property (p_tlb_user) else $error("user buffer read leaked"); // RL14
	// a return whose second cycle is quiet replays the decode address
	property p_ret2;
		int_return_in ##1 !int_return_in |=> restart_vld_out && restart_pc_out == $past(q.pc0);
	endproperty
	a_ret2: assert property (p_ret2) else $error("decode address not replayed"); // RL4
	property p_fp;
		op_valid_in && fp_op_in |=> trap_out;
	endproperty
	a_fp: assert property (p_fp) else $error("floating-point op not trapped"); // RL18
	property p_cmp;
		op_valid_in && assert_op_in && !cond_in |=> trap_out;
	endproperty
	a_cmp: assert property (p_cmp) else $error("failed assert compare not trapped"); // RL19
	// a failure in the same cycle as a new start must still be flagged
	property p_fail;
		chan_fail_in |=> q.cfail;
	endproperty
	a_fail: assert property (p_fail) else $error("channel failure not flagged"); // RL2
	// ack is a single pulse so the master never takes a stale answer twice
	property p_ack;
		hit && !q.ack |=> wb_ack_out ##1 !wb_ack_out;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse"); // RL17

	c_trap: cover property (trap ##1 trap_out);
	c_ret: cover property (int_return_in ##2 !busy_out);
	c_mult: cover property (mult_start_in ##1 q.mult_act ##[1:20] !q.mult_act);
	c_deny: cover property (hit && q.ack && deny);
	c_indirect: cover property (op_valid_in && srca_in == 8'h00 ##1 eff_a_out == q.ipa);
endmodule : special_register_access

// ### design/spr_pkg.sv
// package: offsets, reset values and timing constants of the special register block
package spr_pkg;
	// byte addresses of the special registers on the bus
	localparam logic [11:0] A_CADDR = 12'h000;
	localparam logic [11:0] A_CDATA = 12'h004;
	localparam logic [11:0] A_CCTRL = 12'h008;
	localparam logic [11:0] A_BPROT = 12'h00c;
	localparam logic [11:0] A_PC0 = 12'h010;
	localparam logic [11:0] A_PC1 = 12'h014;
	localparam logic [11:0] A_PC2 = 12'h018;
	localparam logic [11:0] A_LRU = 12'h01c;
	localparam logic [11:0] A_ALUST = 12'h020;
	localparam logic [11:0] A_BPTR = 12'h024;
	localparam logic [11:0] A_FSC = 12'h028;
	localparam logic [11:0] A_CNT = 12'h02c;
	localparam logic [11:0] A_IENV = 12'h030;
	localparam logic [11:0] A_EOP = 12'h034;
	localparam logic [11:0] A_IPA = 12'h038;
	localparam logic [11:0] A_IPB = 12'h03c;
	localparam logic [11:0] A_IPC = 12'h040;
	localparam logic [11:0] A_STAT = 12'h044;
	// translation buffer window: 128 words from here, bit 9 marks it
	localparam logic [11:0] A_TLB = 12'h200;
	localparam int TLB_REGS = 128;
	// field positions
	localparam int CNT_LSB = 16;
	localparam int BPTR_LSB = 5;
	localparam int IENV_MUL = 0;
	localparam int IENV_DIV = 1;
	// reset values
	localparam logic [31:0] RST_WORD = 32'h0;
	localparam logic [15:0] RST_BPROT = 16'h0;
	localparam logic [1:0] RST_IENV = 2'h0;
	// cycles an interrupt return occupies
	localparam logic [1:0] RET_CYC = 2'h2;
endpackage : spr_pkg

// ### sim/special_register_access_tb.sv
// self-checking bench for the special register block
`timescale 1ns/1ns
module special_register_access_tb;
	logic clk_in, reset_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, supervisor_in;
	logic [11:0] wb_adr_in;
	logic [3:0] wb_sel_in;
	logic [31:0] wb_dat_in, wb_dat_out, chan_addr_in, chan_data_in, regb_in, dw_hi_in;
	logic [31:0] dw_lo_in, pc_decode_in, pc_exec_in, pc_done_in, pc_in, restart_pc_out;
	logic [31:0] opb_out, extract_out, target_out, q;
	logic [15:0] chan_ctrl_in, br_off_in;
	logic [7:0] opcode_in, srca_in, srcb_in, dst_in, const_in, eff_a_out, eff_b_out, eff_c_out;
	logic [5:0] lru_in;
	logic chan_start_in, chan_fail_in, mult_start_in, xfer_in, tlb_miss_in, int_return_in;
	logic op_valid_in, use_const_in, br_abs_in, fp_op_in, assert_op_in, cond_in;
	logic mul_exc_in, div_exc_in, trap_out, busy_out, restart_vld_out;
	int error_cnt, total_checks, traps, tr, cyc_n;
	logic [31:0] rq[$];

	special_register_access u_dut (
		.clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
		.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
		.wb_dat_out(wb_dat_out), .supervisor_in(supervisor_in),
		.chan_start_in(chan_start_in), .chan_fail_in(chan_fail_in),
		.chan_addr_in(chan_addr_in), .chan_data_in(chan_data_in),
		.chan_ctrl_in(chan_ctrl_in), .mult_start_in(mult_start_in),
		.xfer_in(xfer_in), .tlb_miss_in(tlb_miss_in), .lru_in(lru_in),
		.int_return_in(int_return_in), .pc_decode_in(pc_decode_in),
		.pc_exec_in(pc_exec_in), .pc_done_in(pc_done_in), .opcode_in(opcode_in),
		.op_valid_in(op_valid_in), .srca_in(srca_in), .srcb_in(srcb_in),
		.dst_in(dst_in), .use_const_in(use_const_in), .const_in(const_in),
		.regb_in(regb_in), .dw_hi_in(dw_hi_in), .dw_lo_in(dw_lo_in),
		.br_abs_in(br_abs_in), .br_off_in(br_off_in), .pc_in(pc_in),
		.fp_op_in(fp_op_in), .assert_op_in(assert_op_in), .cond_in(cond_in),
		.mul_exc_in(mul_exc_in), .div_exc_in(div_exc_in), .trap_out(trap_out),
		.busy_out(busy_out), .restart_vld_out(restart_vld_out),
		.restart_pc_out(restart_pc_out), .eff_a_out(eff_a_out),
		.eff_b_out(eff_b_out), .eff_c_out(eff_c_out), .opb_out(opb_out),
		.extract_out(extract_out), .target_out(target_out)
	);

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// traps and restart addresses are logged as they appear; a hang ends the run
	always @(posedge clk_in) begin
		cyc_n <= cyc_n + 1;
		if (trap_out === 1'b1) traps <= traps + 1;
		if (restart_vld_out === 1'b1) rq.push_back(restart_pc_out);
		if (cyc_n == 3000) begin
			error_cnt++;
			results();
		end
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// classic cycle: request held until ack is seen at a rising edge, then dropped a cycle
	// no local limit: only the bench timeout ends a wait for ack
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_in);
		end while (wb_ack_out !== 1'b1);
		q = wb_dat_out;
		{wb_cyc_in, wb_stb_in} <= 2'b00;
		@(posedge clk_in);
	endtask : bus

	task rc(input string nm, input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask : rc

	// one-cycle event pulse, then room for registered results and any trap
	task fire;
		@(posedge clk_in);
		{chan_start_in, chan_fail_in, mult_start_in, xfer_in, tlb_miss_in, int_return_in} <= '0;
		{op_valid_in, fp_op_in, assert_op_in, mul_exc_in, div_exc_in} <= '0;
		repeat (3) @(posedge clk_in);
	endtask : fire

	// two edges let the logged trap count settle before it is compared
	task tchk(input int add);
		repeat (2) @(posedge clk_in);
		tr += add;
		chk("trap count", tr, traps);
	endtask : tchk

	task results;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results

	initial begin
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in, chan_addr_in, chan_data_in} = '0;
		{regb_in, dw_hi_in, dw_lo_in, pc_decode_in, pc_exec_in, pc_done_in, pc_in} = '0;
		{chan_ctrl_in, br_off_in, opcode_in, srca_in, srcb_in, dst_in, const_in, lru_in} = '0;
		{chan_start_in, chan_fail_in, mult_start_in, xfer_in, tlb_miss_in, int_return_in} = '0;
		{op_valid_in, use_const_in, br_abs_in, fp_op_in, assert_op_in, cond_in} = '0;
		{mul_exc_in, div_exc_in} = '0;
		wb_sel_in = 4'hf;
		supervisor_in = 1'b1;
		reset_in = 1'b1;
		repeat (6) @(posedge clk_in);
		reset_in <= 1'b0;
		rc("cdata reset", spr_pkg::A_CDATA, spr_pkg::RST_WORD);
		// a failure with fresh pin values must leave the captured channel state alone
		{chan_addr_in, chan_data_in, chan_ctrl_in} <= {32'h8000_1000, 32'hcafe_0001, 16'h00a5};
		chan_start_in <= 1'b1;
		fire();
		{chan_addr_in, chan_data_in, chan_ctrl_in} <= {32'h1, 32'h2, 16'h3};
		chan_fail_in <= 1'b1;
		fire();
		rc("caddr", spr_pkg::A_CADDR, 32'h8000_1000);
		rc("cdata", spr_pkg::A_CDATA, 32'hcafe_0001);
		rc("cctrl", spr_pkg::A_CCTRL, 32'h0000_00a5);
		rc("stat", spr_pkg::A_STAT, 32'h0000_0009);
		bus(1'b1, spr_pkg::A_CNT, 32'h2);
		mult_start_in <= 1'b1;
		fire();
		chk("busy", 32'h1, {31'h0, busy_out});
		xfer_in <= 1'b1;
		fire();
		rc("cctrl count", spr_pkg::A_CCTRL, 32'h0001_00a5);
		xfer_in <= 1'b1;
		fire();
		xfer_in <= 1'b1;
		fire();
		rc("count floor", spr_pkg::A_CNT, 32'h0);
		chk("idle", 32'h0, {31'h0, busy_out});
		// user mode: protected and buffer registers refuse, pointers do not
		supervisor_in <= 1'b0;
		rc("user cdata", spr_pkg::A_CDATA, 32'h0);
		tchk(1);
		bus(1'b1, spr_pkg::A_CDATA, 32'h5555_5555);
		tchk(1);
		bus(1'b1, spr_pkg::A_TLB + 12'h004, 32'h1);
		bus(1'b1, spr_pkg::A_BPROT, 32'h0000_ffff);
		rc("user tlb", spr_pkg::A_TLB, 32'h0);
		tchk(3);
		bus(1'b1, spr_pkg::A_IPA, 32'h21);
		tchk(0);
		supervisor_in <= 1'b1;
		rc("cdata kept", spr_pkg::A_CDATA, 32'hcafe_0001);
		rc("tlb kept", spr_pkg::A_TLB + 12'h004, 32'h0);
		rc("bprot kept", spr_pkg::A_BPROT, 32'h0);
		bus(1'b1, spr_pkg::A_TLB + 12'h1fc, 32'ha5a5_0f0f);
		rc("tlb last", spr_pkg::A_TLB + 12'h1fc, 32'ha5a5_0f0f);
		bus(1'b1, spr_pkg::A_IPB, 32'h33);
		bus(1'b1, spr_pkg::A_IPC, 32'h44);
		bus(1'b1, spr_pkg::A_ALUST, 32'h47);
		rc("bptr", spr_pkg::A_BPTR, 32'h2);
		bus(1'b1, spr_pkg::A_FSC, 32'h4);
		rc("alust", spr_pkg::A_ALUST, 32'h44);
		// operand step through all three pointers with a relative branch
		{dw_hi_in, dw_lo_in, regb_in} <= {32'h0000_000a, 32'h1234_5678, 32'h7777_0001};
		{br_abs_in, br_off_in, pc_in, const_in} <= {1'b0, 16'hfffe, 32'h0000_0100, 8'h9c};
		op_valid_in <= 1'b1;
		fire();
		chk("eff a", 32'h21, {24'h0, eff_a_out});
		chk("eff b", 32'h33, {24'h0, eff_b_out});
		chk("eff c", 32'h44, {24'h0, eff_c_out});
		chk("opb", 32'h7777_0001, opb_out);
		chk("extract", 32'ha123_4567, extract_out);
		chk("rel target", 32'h0000_00f8, target_out);
		{srca_in, dst_in, use_const_in, br_abs_in, br_off_in} <= {8'h15, 8'hb0, 2'b11, 16'h0040};
		op_valid_in <= 1'b1;
		fire();
		chk("eff a direct", 32'h15, {24'h0, eff_a_out});
		chk("eff c direct", 32'hb0, {24'h0, eff_c_out});
		chk("const opb", 32'h9c, opb_out);
		chk("abs target", 32'h100, target_out);
		tchk(0);
		bus(1'b1, spr_pkg::A_BPROT, 32'h0000_0002);
		supervisor_in <= 1'b0;
		op_valid_in <= 1'b1;
		fire();
		tchk(1);
		supervisor_in <= 1'b1;
		{use_const_in, srca_in, assert_op_in, cond_in, op_valid_in} <= {1'b0, 8'h60, 3'b111};
		fire();
		tchk(0);
		{assert_op_in, cond_in, op_valid_in} <= 3'b101;
		fire();
		tchk(1);
		{mul_exc_in, op_valid_in} <= 2'b11;
		fire();
		tchk(0);
		bus(1'b1, spr_pkg::A_IENV, 32'h1);
		{mul_exc_in, op_valid_in} <= 2'b11;
		fire();
		tchk(1);
		{div_exc_in, op_valid_in} <= 2'b11;
		fire();
		tchk(0);
		bus(1'b1, spr_pkg::A_IENV, 32'h3);
		{div_exc_in, op_valid_in} <= 2'b11;
		fire();
		tchk(1);
		// trap capture, then a return must replay execute then decode addresses
		{pc_decode_in, pc_exec_in, pc_done_in} <= {32'h0000_1000, 32'h0000_0ffc, 32'h0000_0ff8};
		{opcode_in, fp_op_in, op_valid_in} <= {8'he3, 2'b11};
		fire();
		tchk(1);
		rc("pc0", spr_pkg::A_PC0, 32'h0000_1000);
		rc("pc1", spr_pkg::A_PC1, 32'h0000_0ffc);
		rc("pc2", spr_pkg::A_PC2, 32'h0000_0ff8);
		rc("eop", spr_pkg::A_EOP, 32'h0000_00e3);
		rq.delete();
		int_return_in <= 1'b1;
		fire();
		chk("restart cycles", {30'h0, spr_pkg::RET_CYC}, 32'(rq.size()));
		chk("restart first", 32'h0000_0ffc, rq[0]);
		chk("restart second", 32'h0000_1000, rq[1]);
		{tlb_miss_in, lru_in} <= {1'b1, 6'h2b};
		fire();
		rc("lru", spr_pkg::A_LRU, 32'h0000_002b);
		rc("unmapped", 12'h100, 32'h0);
		tchk(0);
		results();
	end
endmodule : special_register_access_tb
